// file: rtl/fps_array.sv
// flip-flop flash array with program-only-clears behaviour
// assumes writes come only from the sequencer
`timescale 1ns/100ps
module fps_array #(
    parameter int AW = 8
) (
    // clock and reset
    input wire logic clock_in,
    input wire logic arst_n_in,
    // access
    input wire logic [AW-1:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic prog_in,
    output logic [15:0] rdata_out
);
    import fps_pkg::*;
    logic [15:0] mem_q [2**AW];

    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            for (int i = 0; i < 2**AW; i++) begin
                mem_q[i] <= ERASED_WORD;
            end
        end else if (prog_in) begin
            mem_q[addr_in] <= mem_q[addr_in] & wdata_in;
        end
    end

    assign rdata_out = mem_q[addr_in];
endmodule

// file: rtl/fps_pkg.sv
// constants shared by the flash program sequencer and its array model
// assumes a single 200 MHz clock and a synchronous host bus port
// What this block does
// - program setup codes 40h/10h, buffered E8h then D0h; stream 80h then D0h only checks for errors and returns to idle
// - programming a locked block aborts and sets status bits 4 and 1
// - after a program sequence starts, reads return the status word until a read command is written
// - programming only clears ones to zeros, never sets zeros to ones
// - status bit 7 shows busy or ready while the sequencer runs
// - while busy only suspend, status, id, query, array read are accepted
// - on completion bit 4 flags failure, bit 3 flags bad program supply
// - on-chip write buffer of 32 words programmed as one increment
// - after buffered setup bit 7 shows buffer availability, host retries
// - crossing a 32-word boundary doubles the programming time
// - confirm to block address starts buffer programming into the array
// - a non-confirm command at confirm step sets status bits 7, 5, 4
// - an array error during buffer programming stops and sets bits 7, 4
// - buffered program past an erase-block boundary sets bits 5 and 4
// - buffered program with supply below lockout sets bits 4 and 3
package fps_pkg;
    // =========================================================
    // command codes
    localparam logic [7:0] CMD_WORD_A = 8'h40;
    localparam logic [7:0] CMD_WORD_B = 8'h10;
    localparam logic [7:0] CMD_BUF_SETUP = 8'he8;
    localparam logic [7:0] CMD_CONFIRM = 8'hd0;
    localparam logic [7:0] CMD_STREAM = 8'h80;
    localparam logic [7:0] CMD_CLR_STATUS = 8'h50;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
    localparam logic [7:0] CMD_READ_ID = 8'h90;
    localparam logic [7:0] CMD_QUERY = 8'h98;
    localparam logic [7:0] CMD_SUSPEND = 8'hb0;
    localparam logic [7:0] CMD_RESUME = 8'hd0;
    // =========================================================
    // status word bit positions
    localparam int ST_READY = 7;
    localparam int ST_SUSP = 6;
    localparam int ST_SEQ_ERR = 5;
    localparam int ST_PROG_ERR = 4;
    localparam int ST_SUPPLY_ERR = 3;
    localparam int ST_LOCK_ERR = 1;
    localparam int ST_STREAM_BUSY = 0;
    // =========================================================
    // geometry and timing
    localparam int BUF_WORDS = 32;
    localparam int BUF_AW = 5;
    localparam int WORD_PROG_NS = 1000;
    localparam int CLK_NS = 5;
    localparam int WORD_PROG_CYC = (WORD_PROG_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [15:0] ERASED_WORD = 16'hffff;
endpackage

// file: rtl/fps_top.sv
// flash program sequencer: command decode, write buffer, program engine
// assumes host strobes are one cycle, never both at once
`timescale 1ns/100ps
module fps_top #(
    parameter int AW = 8,
    parameter int BLOCK_AW = 6,
    parameter int PROG_CYC = fps_pkg::WORD_PROG_CYC
) (
    // clock and reset
    input wire logic clock_in,
    input wire logic arst_n_in,
    // host bus
    input wire logic [AW-1:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [15:0] rdata_out,
    // device conditions
    input wire logic supply_ok_in,
    input wire logic [2**(AW-BLOCK_AW)-1:0] block_locked_in,
    input wire logic array_fault_in,
    // state
    output logic busy_out
);
    import fps_pkg::*;

    // =========================================================
    // elaboration checks
    if (BLOCK_AW < BUF_AW) begin : g_blk_small
        $error("fps_top: erase block smaller than the write buffer");
    end
    if (BLOCK_AW >= AW) begin : g_blk_big
        $error("fps_top: erase block must be smaller than the array");
    end
    if (PROG_CYC < 1) begin : g_cyc_low
        $error("fps_top: program time below one cycle");
    end
    if (PROG_CYC > 2**29) begin : g_cyc_high
        $error("fps_top: program time overflows the timer");
    end
    if (BUF_WORDS != 2**BUF_AW) begin : g_buf_pow2
        $error("fps_top: buffer depth must match its index width");
    end

    // =========================================================
    // state
    typedef enum logic [8:0] {
        FPS_IDLE = 9'h001,
        FPS_WORD_DATA = 9'h002,
        FPS_BUF_COUNT = 9'h004,
        FPS_BUF_DATA = 9'h008,
        FPS_BUF_CONF = 9'h010,
        FPS_PROG = 9'h020,
        FPS_STREAM_CONF = 9'h040,
        FPS_STREAM = 9'h080,
        FPS_SUSP = 9'h100
    } fps_state_t;

    typedef enum logic [2:0] {
        FPS_RM_ARRAY = 3'h1,
        FPS_RM_STATUS = 3'h2,
        FPS_RM_OTHER = 3'h4
    } fps_rmode_t;

    fps_state_t state_q;
    fps_rmode_t rmode_q;
    logic [7:0] status_err_q;
    logic [15:0] buf_q [BUF_WORDS];
    logic [BUF_AW-1:0] count_q;
    logic [BUF_AW-1:0] fill_q;
    logic [BUF_AW-1:0] idx_q;
    logic [AW-1:0] start_q;
    logic [AW-1:0] block_q;
    logic [AW-1:0] paddr_q;
    logic [31:0] timer_q;
    logic slow_q;
    logic is_word_q;
    logic bad_range_q;
    logic [15:0] arr_rdata;
    logic prog_we;

    function automatic logic [AW-BLOCK_AW-1:0] blk(input logic [AW-1:0] a);
        return a[AW-1:BLOCK_AW];
    endfunction

    // per-word program time; a boundary crossing doubles each word's cycles
    function automatic logic [31:0] word_time(input logic slow);
        return slow ? 32'(2 * PROG_CYC + 1) : 32'(PROG_CYC);
    endfunction

    wire [7:0] cmd = wdata_in[7:0];
    wire busy = (state_q == FPS_PROG) || (state_q == FPS_STREAM);
    wire locked = block_locked_in[blk(addr_in)];
    assign busy_out = busy;

    // =========================================================
    // status word
    logic [7:0] status;
    always_comb begin
        status = status_err_q;
        status[ST_READY] = !busy && state_q != FPS_BUF_DATA;
        if (state_q == FPS_BUF_COUNT) begin
            status[ST_READY] = 1'b1;
        end
        status[ST_SUSP] = (state_q == FPS_SUSP);
        status[ST_STREAM_BUSY] = (state_q == FPS_STREAM);
    end

    // =========================================================
    // sequencer
    wire done = busy && timer_q == 32'd0;
    wire [AW-1:0] end_addr = addr_in + AW'(count_q);

    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_q <= FPS_IDLE;
            status_err_q <= 8'h00;
            count_q <= '0;
            fill_q <= '0;
            idx_q <= '0;
            start_q <= '0;
            block_q <= '0;
            paddr_q <= '0;
            timer_q <= 32'd0;
            slow_q <= 1'b0;
            is_word_q <= 1'b0;
            bad_range_q <= 1'b0;
        end else begin
            if (busy && timer_q != 32'd0) begin
                timer_q <= timer_q - 32'd1;
            end
            case (state_q)
                FPS_IDLE, FPS_SUSP: begin
                    if (wr_in && state_q == FPS_SUSP && cmd == CMD_RESUME) begin
                        state_q <= FPS_PROG;
                    end else if (wr_in && state_q == FPS_IDLE) begin
                        if (cmd == CMD_WORD_A || cmd == CMD_WORD_B) begin
                            state_q <= FPS_WORD_DATA;
                        end else if (cmd == CMD_BUF_SETUP) begin
                            state_q <= FPS_BUF_COUNT;
                            block_q <= addr_in;
                        end else if (cmd == CMD_STREAM) begin
                            state_q <= FPS_STREAM_CONF;
                        end else if (cmd == CMD_CLR_STATUS) begin
                            status_err_q <= 8'h00;
                        end
                    end
                end
                FPS_WORD_DATA: begin
                    if (wr_in) begin
                        if (!supply_ok_in) begin
                            status_err_q[ST_PROG_ERR] <= 1'b1;
                            status_err_q[ST_SUPPLY_ERR] <= 1'b1;
                            state_q <= FPS_IDLE;
                        end else if (locked) begin
                            status_err_q[ST_PROG_ERR] <= 1'b1;
                            status_err_q[ST_LOCK_ERR] <= 1'b1;
                            state_q <= FPS_IDLE;
                        end else begin
                            paddr_q <= addr_in;
                            is_word_q <= 1'b1;
                            count_q <= '0;
                            idx_q <= '0;
                            timer_q <= word_time(1'b0);
                            state_q <= FPS_PROG;
                        end
                    end
                end
                FPS_BUF_COUNT: begin
                    if (wr_in) begin
                        count_q <= wdata_in[BUF_AW-1:0];
                        fill_q <= '0;
                        state_q <= FPS_BUF_DATA;
                    end
                end
                FPS_BUF_DATA: begin
                    if (wr_in) begin
                        if (fill_q == '0) begin
                            start_q <= addr_in;
                            bad_range_q <= blk(end_addr) != blk(addr_in) ||
                                end_addr < addr_in;
                            slow_q <= addr_in[BUF_AW-1:0] != '0 &&
                                (addr_in[BUF_AW-1:0] + count_q) <
                                addr_in[BUF_AW-1:0];
                        end
                        fill_q <= fill_q + BUF_AW'(1);
                        if (fill_q == count_q) begin
                            state_q <= FPS_BUF_CONF;
                        end
                    end
                end
                FPS_BUF_CONF: begin
                    if (wr_in) begin
                        if (cmd != CMD_CONFIRM) begin
                            status_err_q[ST_SEQ_ERR] <= 1'b1;
                            status_err_q[ST_PROG_ERR] <= 1'b1;
                            state_q <= FPS_IDLE;
                        end else if (bad_range_q) begin
                            status_err_q[ST_SEQ_ERR] <= 1'b1;
                            status_err_q[ST_PROG_ERR] <= 1'b1;
                            state_q <= FPS_IDLE;
                        end else if (!supply_ok_in) begin
                            status_err_q[ST_PROG_ERR] <= 1'b1;
                            status_err_q[ST_SUPPLY_ERR] <= 1'b1;
                            state_q <= FPS_IDLE;
                        end else if (block_locked_in[blk(block_q)]) begin
                            status_err_q[ST_PROG_ERR] <= 1'b1;
                            status_err_q[ST_LOCK_ERR] <= 1'b1;
                            state_q <= FPS_IDLE;
                        end else begin
                            paddr_q <= start_q;
                            is_word_q <= 1'b0;
                            idx_q <= '0;
                            timer_q <= word_time(slow_q);
                            state_q <= FPS_PROG;
                        end
                    end
                end
                FPS_STREAM_CONF: begin
                    if (wr_in) begin
                        if (cmd != CMD_CONFIRM) begin
                            status_err_q[ST_SEQ_ERR] <= 1'b1;
                            status_err_q[ST_PROG_ERR] <= 1'b1;
                        end else if (!supply_ok_in) begin
                            status_err_q[ST_PROG_ERR] <= 1'b1;
                            status_err_q[ST_SUPPLY_ERR] <= 1'b1;
                        end else if (locked) begin
                            status_err_q[ST_PROG_ERR] <= 1'b1;
                            status_err_q[ST_LOCK_ERR] <= 1'b1;
                        end
                        state_q <= FPS_IDLE;
                    end
                end
                FPS_PROG: begin
                    if (wr_in && cmd == CMD_SUSPEND) begin
                        state_q <= FPS_SUSP;
                    end else if (array_fault_in) begin
                        status_err_q[ST_PROG_ERR] <= 1'b1;
                        state_q <= FPS_IDLE;
                    end else if (done) begin
                        if (is_word_q || idx_q == count_q) begin
                            state_q <= FPS_IDLE;
                        end else begin
                            idx_q <= idx_q + BUF_AW'(1);
                            paddr_q <= paddr_q + AW'(1);
                            timer_q <= word_time(slow_q);
                        end
                    end
                end
                default: begin
                    state_q <= FPS_IDLE;
                end
            endcase
        end
    end

    // =========================================================
    // word register and write buffer
    logic [15:0] word_q;
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            word_q <= ERASED_WORD;
            for (int i = 0; i < BUF_WORDS; i++) begin
                buf_q[i] <= ERASED_WORD;
            end
        end else if (wr_in && state_q == FPS_WORD_DATA) begin
            word_q <= wdata_in;
        end else if (wr_in && state_q == FPS_BUF_COUNT) begin
            for (int i = 0; i < BUF_WORDS; i++) begin
                buf_q[i] <= ERASED_WORD;
            end
        end else if (wr_in && state_q == FPS_BUF_DATA) begin
            buf_q[fill_q] <= wdata_in;
        end
    end

    assign prog_we = (state_q == FPS_PROG) && done && !array_fault_in &&
        !(wr_in && cmd == CMD_SUSPEND);

    fps_array #(
        .AW(AW)
    ) u_array (
        .clock_in(clock_in),
        .arst_n_in(arst_n_in),
        .addr_in(prog_we ? paddr_q : addr_in),
        .wdata_in(is_word_q ? word_q : buf_q[idx_q]),
        .prog_in(prog_we),
        .rdata_out(arr_rdata)
    );

    // =========================================================
    // read mode and read data
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rmode_q <= FPS_RM_ARRAY;
        end else if (wr_in) begin
            // read commands still accepted while busy
            if (state_q != FPS_IDLE && state_q != FPS_SUSP &&
                state_q != FPS_PROG) begin
                rmode_q <= FPS_RM_STATUS;
            end else if (cmd == CMD_READ_ARRAY) begin
                rmode_q <= FPS_RM_ARRAY;
            end else if (cmd == CMD_READ_ID || cmd == CMD_QUERY) begin
                rmode_q <= FPS_RM_OTHER;
            end else begin
                rmode_q <= FPS_RM_STATUS;
            end
        end
    end

    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rdata_out <= 16'h0000;
        end else if (rd_in) begin
            case (rmode_q)
                FPS_RM_ARRAY: rdata_out <= busy ? 16'h0000 : arr_rdata;
                FPS_RM_OTHER: rdata_out <= 16'h0000;
                default: rdata_out <= {8'h00, status};
            endcase
        end
    end
endmodule

// file: sim/fps_host.sv
// host model: bus master issuing program command sequences
// assumes the device answers reads one cycle after the strobe
`timescale 1ns/100ps
module fps_host import fps_pkg::*; #(
    parameter int AW = 8
) (
    // clock
    input wire logic clock_in,
    // host bus
    output logic [AW-1:0] addr_out,
    output logic [15:0] wdata_out,
    output logic wr_out,
    output logic rd_out,
    input wire logic [15:0] rdata_in
);
    initial begin
        addr_out = '0;
        wdata_out = '0;
        wr_out = 1'b0;
        rd_out = 1'b0;
    end
    // =========================================================
    // bus cycles, released lines show inverted values
    task automatic bus_wr(input logic [AW-1:0] a, input logic [15:0] d);
        @(posedge clock_in);
        addr_out <= a;
        wdata_out <= d;
        wr_out <= 1'b1;
        @(posedge clock_in);
        wr_out <= 1'b0;
        addr_out <= ~a;
        wdata_out <= ~d;
    endtask
    task automatic bus_rd(input logic [AW-1:0] a, output logic [15:0] d);
        @(posedge clock_in);
        addr_out <= a;
        rd_out <= 1'b1;
        @(posedge clock_in);
        rd_out <= 1'b0;
        addr_out <= ~a;
        #1 d = rdata_in;
    endtask
    // =========================================================
    // command sequences
    // setup then data
    task automatic word_prog(input logic [AW-1:0] a, input logic [15:0] d,
        input logic [7:0] setup);
        bus_wr(a, {8'h00, setup});
        bus_wr(a, d);
    endtask
    task automatic poll(output logic [15:0] s);
        s = '0;
        for (int i = 0; i < 400 && !s[ST_READY]; i++) begin
            bus_rd('0, s);
        end
    endtask
    task automatic clear_status();
        bus_wr('0, {8'h00, CMD_CLR_STATUS});
    endtask
    task automatic read_array(input logic [AW-1:0] a, output logic [15:0] d);
        bus_wr(a, {8'h00, CMD_READ_ARRAY});
        bus_rd(a, d);
    endtask
    task automatic buf_load(input logic [AW-1:0] a, input int n,
        input logic [15:0] base, input logic [7:0] confirm);
        logic [15:0] s;
        s = '0;
        for (int i = 0; i < 8 && !s[ST_READY]; i++) begin
            bus_wr(a, {8'h00, CMD_BUF_SETUP});
            bus_rd(a, s);
        end
        bus_wr(a, 16'(n - 1));
        for (int i = 0; i < n; i++) begin
            bus_wr(a + AW'(i), base + 16'(i));
        end
        bus_wr(a, {8'h00, confirm});
    endtask
endmodule

// file: sim/fps_top_props.sv
// port assertions for the flash program sequencer
// assumes one clock and one-cycle host strobes
`timescale 1ns/100ps
module fps_props import fps_pkg::*; #(
    parameter int AW = 8,
    parameter int BLOCK_AW = 6,
    parameter int PROG_CYC = WORD_PROG_CYC
) (
    // clock and reset
    input wire logic clock_in,
    input wire logic arst_n_in,
    // host bus
    input wire logic [AW-1:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [15:0] rdata_out,
    // device conditions
    input wire logic supply_ok_in,
    input wire logic [2**(AW-BLOCK_AW)-1:0] block_locked_in,
    input wire logic array_fault_in,
    // state
    input wire logic busy_out
);
    // =========================================================
    // busy length counter
    localparam int MAX_BUSY = 2 * BUF_WORDS * (PROG_CYC + 1) + 8;
    logic [15:0] busy_cnt_q;
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            busy_cnt_q <= '0;
        end else if (busy_out) begin
            busy_cnt_q <= busy_cnt_q + 16'h0001;
        end else begin
            busy_cnt_q <= '0;
        end
    end
    // =========================================================
    // properties
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!arst_n_in);
    sequence s_busy_start;
        $rose(busy_out);
    endsequence
    sequence s_suspend_cmd;
        wr_in && wdata_in[7:0] == CMD_SUSPEND && busy_out;
    endsequence
    sequence s_fault_hit;
        array_fault_in && busy_out;
    endsequence
    busy_cause_a: assert property (
        s_busy_start |-> $past(wr_in) && $past(supply_ok_in))
        else $error("busy rose without a write or with bad supply");
    busy_min_a: assert property (s_busy_start |-> busy_out[*2])
        else $error("busy too short");
    busy_max_a: assert property (busy_out |-> busy_cnt_q < MAX_BUSY)
        else $error("busy too long");
    busy_status_a: assert property (
        rd_in && busy_out ##1 busy_out |-> !rdata_out[ST_READY])
        else $error("ready bit set while busy");
    rdata_hold_a: assert property (!rd_in |=> $stable(rdata_out))
        else $error("read data changed without a read");
    fault_stop_a: assert property (s_fault_hit |-> ##[1:3] !busy_out)
        else $error("fault did not stop programming");
    suspend_stop_a: assert property (
        s_suspend_cmd |-> ##[1:3] !busy_out)
        else $error("suspend not obeyed");
    locked_gate_a: assert property (
        wr_in && block_locked_in[addr_in[AW-1:BLOCK_AW]] |=> !$rose(busy_out))
        else $error("locked block programming started");
endmodule
bind fps_top fps_props #(.AW(AW), .BLOCK_AW(BLOCK_AW), .PROG_CYC(PROG_CYC))
    props_i (.clock_in(clock_in), .arst_n_in(arst_n_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .supply_ok_in(supply_ok_in),
    .block_locked_in(block_locked_in), .array_fault_in(array_fault_in),
    .busy_out(busy_out));

// file: sim/fps_top_tb.sv
// testbench for the flash program sequencer
// assumes the host model and bound checker are compiled alongside
`timescale 1ns/100ps
module fps_top_tb;
    import fps_pkg::*;
    localparam int AW = 8;
    localparam int PC = 3;
    logic clock_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic [AW-1:0] addr_in;
    logic [15:0] wdata_in;
    logic wr_in;
    logic rd_in;
    logic [15:0] rdata_out;
    logic supply_ok_in = 1'b1;
    logic [3:0] block_locked_in = 4'h0;
    logic array_fault_in = 1'b0;
    logic busy_out;
    int mismatches = 0;
    int check_count = 0;
    int cycles = 0;
    int busy_cyc = 0;
    logic [15:0] s;
    fps_host #(.AW(AW)) host (.clock_in(clock_in), .addr_out(addr_in),
        .wdata_out(wdata_in), .wr_out(wr_in), .rd_out(rd_in),
        .rdata_in(rdata_out));
    fps_top #(.AW(AW), .BLOCK_AW(6), .PROG_CYC(PC)) DUT (
        .clock_in(clock_in), .arst_n_in(arst_n_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .supply_ok_in(supply_ok_in),
        .block_locked_in(block_locked_in), .array_fault_in(array_fault_in),
        .busy_out(busy_out));
    // =========================================================
    // clock, timeout, busy count
    always #2.5 clock_in = ~clock_in;
    always @(posedge clock_in) begin
        cycles <= cycles + 1;
        if (busy_out === 1'b1) begin
            busy_cyc <= busy_cyc + 1;
        end
        if (cycles == 20000) begin
            mismatches++;
            tally_and_finish();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        if (mismatches == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // =========================================================
    // scenarios
    task automatic t_word();
        host.bus_wr(8'h11, 16'h0000);
        host.read_array(8'h11, s);
        check(s, ERASED_WORD);
        host.word_prog(8'h05, 16'h1234, CMD_WORD_A);
        host.bus_rd(8'h33, s);
        check(s & 16'h0080, 16'h0000);
        host.poll(s);
        check(s & 16'h00ff, 16'h0080);
        host.word_prog(8'h05, 16'h00f0, CMD_WORD_B);
        host.poll(s);
        host.word_prog(8'h05, 16'hffff, CMD_WORD_A);
        host.poll(s);
        host.read_array(8'h05, s);
        check(s, 16'h0030);
    endtask
    task automatic t_suspend();
        host.word_prog(8'h06, 16'h5555, CMD_WORD_A);
        host.bus_wr(8'h06, {8'h00, CMD_SUSPEND});
        host.bus_rd(8'h06, s);
        check(s & 16'h0040, 16'h0040);
        host.bus_wr(8'h06, {8'h00, CMD_RESUME});
        host.poll(s);
        host.read_array(8'h06, s);
        check(s, 16'h5555);
    endtask
    task automatic t_errors();
        block_locked_in <= 4'h2;
        host.word_prog(8'h45, 16'h0000, CMD_WORD_A);
        host.poll(s);
        check(s & 16'h00ff, 16'h0092);
        host.bus_rd(8'h45, s);
        check(s & 16'h00ff, 16'h0092);
        host.clear_status();
        block_locked_in <= 4'h0;
        host.read_array(8'h45, s);
        check(s, ERASED_WORD);
        supply_ok_in <= 1'b0;
        host.word_prog(8'h07, 16'h0000, CMD_WORD_A);
        host.poll(s);
        check(s & 16'h00ff, 16'h0098);
        host.clear_status();
        host.buf_load(8'h20, 1, 16'h0000, CMD_CONFIRM);
        host.poll(s);
        check(s & 16'h0018, 16'h0018);
        supply_ok_in <= 1'b1;
        host.clear_status();
        host.poll(s);
        check(s & 16'h00ff, 16'h0080);
        host.buf_load(8'h10, 1, 16'h0000, CMD_CLR_STATUS);
        host.poll(s);
        check(s & 16'h00ff, 16'h00b0);
        host.clear_status();
        host.buf_load(8'h3e, 4, 16'h0000, CMD_CONFIRM);
        host.poll(s);
        check(s & 16'h0030, 16'h0030);
        host.clear_status();
        host.bus_wr(8'h00, {8'h00, CMD_STREAM});
        host.bus_wr(8'h00, {8'h00, CMD_CONFIRM});
        host.poll(s);
        check(s & 16'h00ff, 16'h0080);
    endtask
    task automatic t_buffer();
        int b0;
        int cyc_a;
        host.buf_load(8'h80, BUF_WORDS, 16'ha500, CMD_CONFIRM);
        host.bus_wr(8'h80, {8'h00, CMD_READ_ARRAY});
        host.bus_rd(8'h80, s);
        check(s, 16'h0000);
        host.bus_wr(8'h80, {8'h00, CMD_READ_STATUS});
        host.poll(s);
        check(s & 16'h00ff, 16'h0080);
        for (int i = 0; i < BUF_WORDS; i++) begin
            host.read_array(8'h80 + 8'(i), s);
            check(s, 16'ha500 + 16'(i));
        end
        b0 = busy_cyc;
        host.buf_load(8'hc0, 4, 16'h1100, CMD_CONFIRM);
        host.poll(s);
        cyc_a = busy_cyc - b0;
        b0 = busy_cyc;
        host.buf_load(8'hde, 4, 16'h2200, CMD_CONFIRM);
        host.poll(s);
        check(16'(cyc_a < 8 * PC), 16'h0001);
        check(16'(busy_cyc - b0 >= 8 * PC), 16'h0001);
        host.read_array(8'he1, s);
        check(s, 16'h2203);
        host.buf_load(8'h20, 2, 16'h0000, CMD_CONFIRM);
        repeat (2) @(posedge clock_in);
        array_fault_in <= 1'b1;
        host.poll(s);
        array_fault_in <= 1'b0;
        check(s & 16'h00ff, 16'h0090);
        host.clear_status();
    endtask
    initial begin
        repeat (20) @(posedge clock_in);
        arst_n_in <= 1'b1;
        t_word();
        t_suspend();
        t_errors();
        t_buffer();
        tally_and_finish();
    end
endmodule
